// >>> common/canc_pkg.sv
// Register map, field layout and reset values of the CAN config block
`default_nettype none
package canc_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// Register byte offsets
	localparam logic [7:0] OFS_TIMING = 8'h00;
	localparam logic [7:0] OFS_INT = 8'h04;
	localparam logic [7:0] OFS_FILT0 = 8'h08;
	localparam logic [7:0] OFS_FILT1 = 8'h0c;
	localparam logic [7:0] OFS_CTRL = 8'h10;
	// Timing register fields
	localparam int POS_PRESCALER = 0;
	localparam int POS_JUMP = 6;
	localparam int POS_PROP = 8;
	localparam int POS_PHASE1 = 11;
	localparam int POS_THREE_SAMPLE = 14;
	localparam int POS_PHASE2_PROG = 15;
	localparam int POS_PHASE2 = 16;
	// Interrupt register fields
	localparam int POS_EN_HI = 27;
	localparam int POS_EN_LO = 16;
	localparam int POS_FL_HI = 11;
	localparam int POS_FL_LO = 0;
	// Event index inside the nine-bit event vectors
	localparam int EV_SYS_ERR = 5;
	localparam int EV_MODE = 3;
	// Flags that software may clear: all but the system error flag
	localparam logic [8:0] FLAG_W1C = 9'h1df;
	// Control register fields
	localparam int POS_MODE = 21;
	localparam int POS_ON = 15;
	localparam logic [2:0] MODE_CONFIG = 3'h4;
	// Filter byte fields
	localparam int POS_FIFO_SELECT = 0;
	localparam int POS_MASK_SELECT = 5;
	localparam int POS_FEN = 7;
	localparam int NUM_FILT = 8;
	localparam int NUM_MASK = 4;
	// Reset values
	localparam logic [2:0] RST_MODE = 3'h4;
	localparam logic [5:0] RST_PRESCALER = 6'h00;
	localparam logic [6:0] RST_TQ_CNT = 7'h00;
endpackage : canc_pkg
`default_nettype wire

// >>> rtl/canc_cfg.sv
// CAN bit timing, interrupt and acceptance filter configuration block
// How it works
// [R1] Propagation segment lasts field value plus one quanta, one to eight.
// [R2] Jump width lasts field value plus one quanta, one to four.
// [R3] Time quantum lasts two times prescaler plus one clock periods.
// [R4] Phase two not above phase one; when not programmable, set automatically. A programmed phase two is taken as written, not checked against phase one.
// [R5] Software avoids three-sample mode while prescaler is below two.
// [R6] Software keeps total quanta per bit above seven.
// [R7] Timing register writes take effect only in configuration mode.
// [R8] Nine interrupt enables sit in bits 31-27 and 19-16.
// [R9] Matching event flags in bits 15-11 and 3-0, all reset zero.
// [R10] System error flag clears only by turning the module off and on.
// [R11] A filter takes part in matching only while enabled.
// [R12] Each enabled filter compares through its selected mask, zero to three.
// [R13] A matching message goes to the FIFO named by the filter.
// [R14] Four filters per register, one per byte: enable, mask, FIFO.
// [R15] Filter fields change only while that filter is disabled.
// [R16] Interrupt is high while any flag and its enable are both set.
`default_nettype none
module canc_cfg (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [canc_pkg::ADDR_W-1:0] i_paddr,
	input wire logic [canc_pkg::DATA_W-1:0] i_pwdata,
	output logic [canc_pkg::DATA_W-1:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Events from the protocol engine, one-cycle pulses
	input wire logic [8:0] i_event,
	// Received message and per filter, per mask match results
	input wire logic i_rx_valid,
	input wire logic [canc_pkg::NUM_FILT*canc_pkg::NUM_MASK-1:0] i_mask_match,
	// Store request towards the receive FIFOs
	output logic o_store_valid,
	output logic [4:0] o_store_fifo,
	output logic [2:0] o_store_filter,
	// Bit timing towards the bit engine
	output logic o_tq_tick,
	output logic [3:0] o_prop_tq,
	output logic [2:0] o_jump_tq,
	output logic [3:0] o_phase1_tq,
	output logic [3:0] o_phase2_tq,
	output logic [4:0] o_quanta_per_bit,
	output logic o_three_sample,
	// Module state and interrupt
	output logic o_module_on,
	output logic [2:0] o_operating_mode,
	output logic o_irq
);
	import canc_pkg::*;

	typedef struct packed {
		logic [5:0] prescaler;
		logic [1:0] jump;
		logic [2:0] prop;
		logic [2:0] phase1;
		logic three_sample;
		logic phase2_prog;
		logic [2:0] phase2;
		logic [8:0] irq_en;
		logic [8:0] flags;
		logic [NUM_FILT-1:0][7:0] filt;
		logic on;
		logic [2:0] mode;
		logic [6:0] tq_cnt;
		logic tq_tick;
		logic [DATA_W-1:0] rdata;
		logic store_valid;
		logic [4:0] store_fifo;
		logic [2:0] store_filter;
	} canc_state_t;

	canc_state_t st_q;
	canc_state_t st_d;

	logic setup;
	logic wr;
	logic hit_map;
	logic [DATA_W-1:0] timing_word;
	logic [DATA_W-1:0] int_word;
	logic [DATA_W-1:0] ctrl_word;
	logic [2:0] phase2_eff;

	// Returns true when the offset belongs to a register
	function automatic logic canc_mapped(input logic [ADDR_W-1:0] a);
		canc_mapped = (a == OFS_TIMING) || (a == OFS_INT) ||
			(a == OFS_FILT0) || (a == OFS_FILT1) || (a == OFS_CTRL);
	endfunction : canc_mapped

	// New filter byte: fields held while the filter is enabled before the write, even when that write disables it
	function automatic logic [7:0] canc_filt_wr(input logic [7:0] cur,
		input logic [7:0] wv);
		if (cur[POS_FEN]) begin
			canc_filt_wr = {wv[POS_FEN], cur[6:0]}; // R15
		end else begin
			canc_filt_wr = wv; // R14
		end
	endfunction : canc_filt_wr

	assign setup = i_psel && !i_penable;
	assign wr = i_psel && i_penable && i_pwrite;
	assign hit_map = canc_mapped(i_paddr);

	// Auto phase two tracks phase one, so it never exceeds it
	assign phase2_eff = st_q.phase2_prog ? st_q.phase2 : st_q.phase1; // R4

	always_comb begin
		timing_word = '0;
		timing_word[POS_PRESCALER +: 6] = st_q.prescaler;
		timing_word[POS_JUMP +: 2] = st_q.jump;
		timing_word[POS_PROP +: 3] = st_q.prop;
		timing_word[POS_PHASE1 +: 3] = st_q.phase1;
		timing_word[POS_THREE_SAMPLE] = st_q.three_sample;
		timing_word[POS_PHASE2_PROG] = st_q.phase2_prog;
		timing_word[POS_PHASE2 +: 3] = phase2_eff;
		int_word = '0;
		int_word[POS_EN_HI +: 5] = st_q.irq_en[8:4]; // R8
		int_word[POS_EN_LO +: 4] = st_q.irq_en[3:0]; // R8
		int_word[POS_FL_HI +: 5] = st_q.flags[8:4]; // R9
		int_word[POS_FL_LO +: 4] = st_q.flags[3:0]; // R9
		ctrl_word = '0;
		ctrl_word[POS_MODE +: 3] = st_q.mode;
		ctrl_word[POS_ON] = st_q.on;
	end

	always_comb begin
		logic [8:0] ev;
		logic [8:0] clr;
		logic [NUM_FILT-1:0][7:0] wf;
		logic [2:0] mask_select;
		st_d = st_q;
		ev = i_event;
		clr = '0;
		wf = '0;
		mask_select = '0;

		// Quantum tick every 2*(prescaler+1) clocks while on
		if (!st_q.on || st_q.tq_cnt == {st_q.prescaler, 1'b1}) begin
			st_d.tq_cnt = RST_TQ_CNT; // R3
		end else begin
			st_d.tq_cnt = st_q.tq_cnt + 7'h01; // R3
		end
		st_d.tq_tick = st_q.on && st_q.tq_cnt == {st_q.prescaler, 1'b1};

		// Read data is captured in setup so the access phase needs no wait
		if (setup) begin
			unique case (i_paddr)
				OFS_TIMING: st_d.rdata = timing_word;
				OFS_INT: st_d.rdata = int_word;
				OFS_FILT0: st_d.rdata = st_q.filt[3:0];
				OFS_FILT1: st_d.rdata = st_q.filt[7:4];
				OFS_CTRL: st_d.rdata = ctrl_word;
				default: st_d.rdata = '0;
			endcase
		end

		if (wr) begin
			unique case (i_paddr)
				OFS_TIMING: begin
					if (st_q.mode == MODE_CONFIG) begin // R7
						st_d.prescaler = i_pwdata[POS_PRESCALER +: 6];
						st_d.jump = i_pwdata[POS_JUMP +: 2];
						st_d.prop = i_pwdata[POS_PROP +: 3];
						st_d.phase1 = i_pwdata[POS_PHASE1 +: 3];
						st_d.three_sample = i_pwdata[POS_THREE_SAMPLE];
						st_d.phase2_prog = i_pwdata[POS_PHASE2_PROG];
						st_d.phase2 = i_pwdata[POS_PHASE2 +: 3];
					end
				end
				OFS_INT: begin
					st_d.irq_en = {i_pwdata[POS_EN_HI +: 5],
						i_pwdata[POS_EN_LO +: 4]}; // R8
					clr = {i_pwdata[POS_FL_HI +: 5],
						i_pwdata[POS_FL_LO +: 4]} & FLAG_W1C; // R10
				end
				OFS_FILT0, OFS_FILT1: begin
					wf = {i_pwdata, i_pwdata};
					for (int f = 0; f < NUM_FILT; f++) begin
						if ((f < 4) == (i_paddr == OFS_FILT0)) begin
							st_d.filt[f] = canc_filt_wr(st_q.filt[f],
								wf[f]); // R15
						end
					end
				end
				OFS_CTRL: begin
					st_d.mode = i_pwdata[POS_MODE +: 3];
					st_d.on = i_pwdata[POS_ON];
					if (i_pwdata[POS_MODE +: 3] != st_q.mode) begin
						ev[EV_MODE] = 1'b1;
					end
					if (!st_q.on && i_pwdata[POS_ON]) begin
						clr[EV_SYS_ERR] = 1'b1; // R10
					end
				end
				default: begin
				end
			endcase
		end

		// A new event wins over a clear in the same cycle
		st_d.flags = (st_q.flags & ~clr) | ev; // R9

		// Lowest numbered enabled filter whose selected mask matches wins
		st_d.store_valid = 1'b0;
		for (int f = NUM_FILT - 1; f >= 0; f--) begin
			mask_select = {1'b0, st_q.filt[f][POS_MASK_SELECT +: 2]}; // R12
			if (i_rx_valid && st_q.filt[f][POS_FEN] && // R11
				i_mask_match[f*NUM_MASK + int'(mask_select)]) begin
				st_d.store_valid = 1'b1;
				st_d.store_fifo = st_q.filt[f][POS_FIFO_SELECT +: 5]; // R13
				st_d.store_filter = 3'(f);
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= '0;
			st_q.prescaler <= RST_PRESCALER;
			st_q.mode <= RST_MODE;
			st_q.tq_cnt <= RST_TQ_CNT;
		end else begin
			st_q <= st_d;
		end
	end

	// Zero wait states; unmapped offsets answer with an error
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !hit_map;
	assign o_prdata = st_q.rdata;

	assign o_store_valid = st_q.store_valid;
	assign o_store_fifo = st_q.store_fifo;
	assign o_store_filter = st_q.store_filter;

	assign o_tq_tick = st_q.tq_tick;
	assign o_prop_tq = {1'b0, st_q.prop} + 4'h1; // R1
	assign o_jump_tq = {1'b0, st_q.jump} + 3'h1; // R2
	assign o_phase1_tq = {1'b0, st_q.phase1} + 4'h1;
	assign o_phase2_tq = {1'b0, phase2_eff} + 4'h1; // R4
	// Sync segment plus the three programmed segments
	assign o_quanta_per_bit = 5'h1 + {1'b0, o_prop_tq} +
		{1'b0, o_phase1_tq} + {1'b0, o_phase2_tq};
	assign o_three_sample = st_q.three_sample;

	assign o_module_on = st_q.on;
	assign o_operating_mode = st_q.mode;
	assign o_irq = |(st_q.irq_en & st_q.flags); // R16
endmodule : canc_cfg
`default_nettype wire

// >>> test/canc_cfg_properties.sv
// Port-level checker of the CAN config block
`default_nettype none
module canc_cfg_properties (
	// Clock, reset, bus and protocol engine inputs
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [8:0] i_event,
	input wire logic i_rx_valid,
	// Outputs watched
	input wire logic o_pslverr,
	input wire logic o_irq,
	input wire logic o_store_valid,
	input wire logic o_tq_tick,
	input wire logic [3:0] o_prop_tq,
	input wire logic [2:0] o_jump_tq,
	input wire logic [3:0] o_phase1_tq,
	input wire logic [3:0] o_phase2_tq,
	input wire logic [4:0] o_quanta_per_bit,
	input wire logic [2:0] o_operating_mode
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	wire acc = i_psel && i_penable;
	err_resp_a: assert property (acc && i_paddr[1:0] == 2'h0 |->
		o_pslverr == (i_paddr > 8'h10)) else $error("bad error response");
	irq_rise_a: assert property ($rose(o_irq) |->
		$past(|i_event || acc && i_pwrite)) else $error("irq without cause");
	irq_fall_a: assert property ($fell(o_irq) |->
		$past(acc && i_pwrite)) else $error("irq fell without write");
	store_src_a: assert property (o_store_valid |->
		$past(i_rx_valid)) else $error("store without message");
	tick_gap_a: assert property (o_tq_tick |=> !o_tq_tick)
		else $error("quantum tick too close");
	prop_span_a: assert property (o_prop_tq inside {[1:8]})
		else $error("propagation length out of range");
	jump_span_a: assert property (o_jump_tq inside {[1:4]})
		else $error("jump width out of range");
	bit_sum_a: assert property (o_quanta_per_bit ==
		5'(1 + o_prop_tq + o_phase1_tq + o_phase2_tq))
		else $error("quanta per bit wrong");
	timing_lock_a: assert property ($changed(o_prop_tq) |->
		$past(o_operating_mode) == 3'h4) else $error("timing changed");
	cover property (o_store_valid);
	cover property ($fell(o_irq));
	cover property (o_pslverr);
endmodule : canc_cfg_properties
bind canc_cfg canc_cfg_properties chk (.*);
`default_nettype wire

// >>> test/canc_peer.sv
// Model of the protocol engine side: events and received messages
`default_nettype none
module canc_peer (
	// Clock
	input wire logic i_mclk,
	// Towards the block
	output logic o_rx_valid,
	output logic [31:0] o_mask_match,
	output logic [8:0] o_event
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_rx_valid = 1'b0;
		o_mask_match = 32'h0;
		o_event = 9'h0;
	end
	// Stale match lines go inverted so no old hit can survive
	task automatic msg(input logic [31:0] m, input int gap);
		repeat (gap + 1) @(posedge i_mclk);
		o_rx_valid <= 1'b1;
		o_mask_match <= m;
		@(posedge i_mclk);
		o_rx_valid <= 1'b0;
		o_mask_match <= ~m;
	endtask : msg
	task automatic ev(input logic [8:0] e);
		@(posedge i_mclk);
		o_event <= e;
		@(posedge i_mclk);
		o_event <= 9'h0;
	endtask : ev
endmodule : canc_peer
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench of the CAN config block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import canc_pkg::*;
	logic i_mclk, i_rst_n, i_psel, i_penable, i_pwrite, i_rx_valid;
	logic [7:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata, i_mask_match;
	logic [8:0] i_event;
	logic o_pready, o_pslverr, o_store_valid, o_tq_tick, o_three_sample;
	logic o_module_on, o_irq;
	logic [4:0] o_store_fifo, o_quanta_per_bit;
	logic [2:0] o_store_filter, o_jump_tq, o_operating_mode;
	logic [3:0] o_prop_tq, o_phase1_tq, o_phase2_tq;
	int errors, total_checks, seed, p, t;
	logic [31:0] rq[$];
	logic [7:0] sq[$];
	canc_cfg DUT (.*);
	canc_peer peer (.i_mclk, .o_rx_valid(i_rx_valid),
		.o_mask_match(i_mask_match), .o_event(i_event));
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	task automatic chk(input string n, input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			errors++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_mclk);
		i_penable <= 1'b1;
		// No wait limit here: a hang is ended by the watchdog
		do @(posedge i_mclk); while (o_pready !== 1'b1);
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_mclk);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : close_out
	// Results are matched in order against the noted expectations
	always @(posedge i_mclk) begin
		if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1)
			chk("read", o_prdata, rq.pop_front());
		if (i_rst_n && o_store_valid !== 1'b0) begin
			// An unexpected or unknown store pulse is a mismatch
			if (sq.size() > 0)
				chk("store", {o_store_filter, o_store_fifo}, sq.pop_front());
			else
				chk("store extra", o_store_valid, 1'b0);
		end
	end
	initial begin
		#100000;
		errors++;
		close_out;
	end
	initial begin
		seed = 32'h2092;
		{i_rst_n, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
		repeat (2) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		@(posedge i_mclk);
		for (int i = 0; i < 6; i++)
			rd(8'(i * 4), i == 4 ? 32'h00800000 : 32'h0);
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, OFS_TIMING, 32'h3800 | i << 8 | (i & 3) << 6);
			chk("prop", o_prop_tq, i + 1);
			chk("jump", o_jump_tq, (i & 3) + 1);
			chk("quanta", o_quanta_per_bit, i + 18);
			chk("phase2 auto", o_phase2_tq, 4'h8);
		end
		apb(1'b1, OFS_TIMING, 32'h0005f8c2);
		chk("phase2 prog", o_phase2_tq, 4'h6);
		chk("phase1", o_phase1_tq, 4'h8);
		chk("jump prog", o_jump_tq, 3'h4);
		chk("three sample", o_three_sample, 1'b1);
		chk("quanta prog", o_quanta_per_bit, 5'h10);
		rd(OFS_TIMING, 32'h0005f8c2);
		p = $random(seed) & 7;
		apb(1'b1, OFS_TIMING, 32'h3800 | p);
		apb(1'b1, OFS_CTRL, 32'h808000);
		chk("on", o_module_on, 1'b1);
		chk("mode config", o_operating_mode, MODE_CONFIG);
		chk("single sample", o_three_sample, 1'b0);
		for (int k = 0; k < 2; k++) begin
			t = 0;
			do begin
				@(negedge i_mclk);
				t++;
			end while (o_tq_tick !== 1'b1 && t < 200);
		end
		chk("tick gap", t, 2 * (p + 1));
		@(posedge i_mclk);
		apb(1'b1, OFS_CTRL, 32'h8000);
		chk("mode normal", o_operating_mode, 3'h0);
		apb(1'b1, OFS_TIMING, 32'h3f00);
		chk("locked prop", o_prop_tq, 4'h1);
		$display("timing test done");
		apb(1'b1, OFS_INT, 32'hf80f0000);
		for (int i = 0; i < 9; i++)
			peer.ev(9'(1 << i));
		rd(OFS_INT, 32'hf80ff80f);
		chk("irq on", o_irq, 1'b1);
		apb(1'b1, OFS_INT, 32'h0000f80f);
		rd(OFS_INT, 32'h00001000);
		chk("irq off", o_irq, 1'b0);
		apb(1'b1, OFS_CTRL, 32'h0);
		chk("off", o_module_on, 1'b0);
		apb(1'b1, OFS_CTRL, 32'h8000);
		rd(OFS_INT, 32'h0);
		// Irq must follow the flag, not only the enable
		apb(1'b1, OFS_INT, 32'h00010000);
		peer.ev(9'h001);
		rd(OFS_INT, 32'h00010001);
		chk("irq tx", o_irq, 1'b1);
		apb(1'b1, OFS_INT, 32'h00010001);
		chk("irq cleared", o_irq, 1'b0);
		$display("interrupt test done");
		apb(1'b1, OFS_FILT0, 32'hffc5);
		sq.push_back(8'h05);
		peer.msg(32'h4, 0);
		sq.push_back(8'h3f);
		peer.msg(32'h82, 2);
		peer.msg(32'hf00, 0);
		apb(1'b1, OFS_FILT0, 32'hff80);
		rd(OFS_FILT0, 32'hffc5);
		apb(1'b1, OFS_FILT0, 32'hff05);
		rd(OFS_FILT0, 32'hff45);
		apb(1'b1, OFS_FILT0, 32'hff83);
		rd(OFS_FILT0, 32'hff83);
		chk("stores left", sq.size(), 0);
		$display("filter test done");
		close_out;
	end
endmodule : tb_top
`default_nettype wire
